// >>> shared/aicr_pkg.sv
package aicr_pkg;

  localparam int unsigned CLK_HZ = 125_000_000; // system clock rate
  localparam int unsigned CLK_PERIOD_NS = 8; // system clock period
  localparam int unsigned SLEEP_MIN_NS = 500; // least sleep before output
  localparam int unsigned SLEEP_CYC = (SLEEP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned OSC_HZ = 1_800_000; // on-chip modulator rate
  localparam int unsigned OSC_DIV = CLK_HZ / OSC_HZ; // clocks per internal sample
  localparam int unsigned EXT_DIV = 5; // external clock edges per sample
  localparam int unsigned WORD_PER_NULL = 8; // null periods per output word
  localparam int unsigned WORD_BITS = 32; // bits per output word
  localparam int unsigned PROG_MIN_BITS = 13; // input bits needed to program
  localparam int unsigned SCK_HALF = 4; // clocks per serial clock half
  localparam logic [7:0] EXT_IDLE_MAX = 8'hff; // no edge this long: grounded
  localparam logic [3:0] OSR_LOG2_MIN = 4'h6; // ratio 64
  localparam logic [3:0] OSR_LOG2_MAX = 4'hf; // ratio 32768
  localparam logic [3:0] OSR_CODE_LAST = 4'h9; // highest explicit speed code
  localparam logic [12:0] CONFIG_RST = 13'h1fff; // largest ratio after reset

  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_CONFIG = 8'h08;
  localparam logic [7:0] REG_RESULT = 8'h0c;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h10;
  localparam logic [7:0] REG_IRQ_MASK = 8'h14;
  localparam int unsigned CTRL_FORCE_OSC_BIT = 0; // ignore external clock pin
  localparam logic [1:0] IRQ_MASK_RST = 2'h0;

  // sequencer states, gray along conv -> sleep -> out
  typedef enum logic [1:0] {
    ST_CONV = 2'b00,
    ST_SLEEP = 2'b01,
    ST_OUT = 2'b11
  } aicr_state_type;

  // serial output pins
  typedef struct packed {
    logic sck; // generated serial clock
    logic sdo; // serial data, low = result ready
    logic busy; // conversion running
  } aicr_pins_type;

  // sticky interrupt events
  typedef struct packed {
    logic word_sent; // 32nd rising edge passed
    logic conv_done; // conversion finished
  } aicr_event_type;

endpackage

// >>> design/aicr_readout.sv
// Chosen here: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module aicr_readout #(
  parameter int unsigned OSC_DIV_P = aicr_pkg::OSC_DIV, // clocks per internal sample
  parameter int unsigned SCK_HALF_P = aicr_pkg::SCK_HALF, // clocks per serial clock half
  parameter logic [3:0] OSR_LOG2_RST_P = aicr_pkg::OSR_LOG2_MAX // ratio exponent after reset
) (
  input wire logic hclk, // system clock
  input wire logic hresetn, // async reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // transfer size
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic hreadyout, // slave ready
  output logic [31:0] hrdata, // read data
  output logic hresp, // response, always okay
  output logic irq, // level interrupt
  input wire logic clock_source_select, // high: internal serial clock
  input wire logic external_clock_input, // modulator clock pin, grounded if unused
  input wire logic sdi, // serial configuration input
  input wire logic [30:0] result_in, // converted value from the modulator
  output aicr_pkg::aicr_pins_type serial_pins // sck, sdo, busy
);
  import aicr_pkg::*;

  // refuse settings the counters cannot hold
  if (OSC_DIV_P < 1 || OSC_DIV_P > 65535 || SCK_HALF_P < 1 || SCK_HALF_P > 255 ||
      OSR_LOG2_RST_P < OSR_LOG2_MIN || OSR_LOG2_RST_P > OSR_LOG2_MAX) begin : g_bad
    $error("aicr_readout: parameter out of range");
  end

  localparam logic [15:0] OSC_LAST = 16'(OSC_DIV_P - 1);
  localparam logic [2:0] EXT_LAST = 3'(EXT_DIV - 1);
  localparam logic [7:0] HALF_LAST = 8'(SCK_HALF_P - 1);
  localparam logic [7:0] SLEEP_LAST = 8'(SLEEP_CYC - 1);
  localparam logic [5:0] WORD_END = 6'(WORD_BITS);
  localparam logic [5:0] PROG_LAST = 6'(PROG_MIN_BITS - 1);
  localparam logic [4:0] NULL_SHIFT = 5'($clog2(WORD_PER_NULL));

  // speed code to ratio exponent; codes outside 1..9 pick the largest ratio
  function automatic logic [3:0] osr_decode(input logic [3:0] code);
    if (code != 4'h0 && code <= OSR_CODE_LAST) begin
      return 4'(code + 4'h5);
    end
    return OSR_LOG2_MAX;
  endfunction

  // ---------------- modulator sample rate ----------------
  logic ext_d_reg, ext_d_next; // previous external clock level
  logic [2:0] ext_div_reg, ext_div_next; // external edge divider
  logic [7:0] ext_idle_reg, ext_idle_next; // clocks since last external edge
  logic [15:0] osc_cnt_reg, osc_cnt_next; // internal oscillator divider
  logic ext_rise; // external clock rising edge
  logic use_ext; // external clock is live and allowed
  logic sample_en; // one modulator sample
  logic [31:0] ctrl_reg, ctrl_next; // control register

  // choose the sample source and divide it down
  always_comb begin
    ext_d_next = external_clock_input;
    ext_rise = external_clock_input & ~ext_d_reg;
    ext_idle_next = ext_rise ? 8'h00 :
                    (ext_idle_reg == EXT_IDLE_MAX) ? ext_idle_reg : 8'(ext_idle_reg + 8'h01);
    use_ext = (ext_idle_reg != EXT_IDLE_MAX) && !ctrl_reg[CTRL_FORCE_OSC_BIT];
    osc_cnt_next = (osc_cnt_reg == OSC_LAST) ? 16'h0000 : 16'(osc_cnt_reg + 16'h0001);
    ext_div_next = ext_div_reg;
    if (ext_rise) begin
      ext_div_next = (ext_div_reg == EXT_LAST) ? 3'h0 : 3'(ext_div_reg + 3'h1);
    end
    if (use_ext) begin
      sample_en = ext_rise && (ext_div_reg == EXT_LAST);
    end else begin
      sample_en = (osc_cnt_reg == OSC_LAST);
    end
  end

  // register the rate logic
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_d_reg <= 1'b0;
      ext_div_reg <= 3'h0;
      ext_idle_reg <= EXT_IDLE_MAX;
      osc_cnt_reg <= 16'h0000;
    end else begin
      ext_d_reg <= ext_d_next;
      ext_div_reg <= ext_div_next;
      ext_idle_reg <= ext_idle_next;
      osc_cnt_reg <= osc_cnt_next;
    end
  end

  // ---------------- conversion and readout sequencer ----------------
  aicr_state_type state_reg, state_next; // sequencer state
  aicr_pins_type pins_reg, pins_next; // serial pins
  logic [18:0] conv_cnt_reg, conv_cnt_next; // samples in this conversion
  logic [18:0] conv_last; // final sample index
  logic [7:0] sleep_cnt_reg, sleep_cnt_next; // clocks spent asleep
  logic [7:0] half_cnt_reg, half_cnt_next; // clocks in this sck half
  logic [5:0] bit_cnt_reg, bit_cnt_next; // rising edges so far
  logic [31:0] out_shift_reg, out_shift_next; // word being sent
  logic [12:0] in_shift_reg, in_shift_next; // configuration bits taken in
  logic [12:0] config_reg, config_next; // accepted configuration
  logic [3:0] osr_log2_reg, osr_log2_next; // active ratio exponent
  logic [31:0] result_reg, result_next; // last word loaded
  aicr_event_type ev; // events this cycle

  // conversion spans ratio times eight samples; sample rate is untouched
  assign conv_last = 19'((19'h00001 << (5'(osr_log2_reg) + NULL_SHIFT)) - 19'h00001);

  // next state of the sequencer
  always_comb begin
    state_next = state_reg;
    pins_next = pins_reg;
    conv_cnt_next = conv_cnt_reg;
    sleep_cnt_next = sleep_cnt_reg;
    half_cnt_next = half_cnt_reg;
    bit_cnt_next = bit_cnt_reg;
    out_shift_next = out_shift_reg;
    in_shift_next = in_shift_reg;
    config_next = config_reg;
    osr_log2_next = osr_log2_reg;
    result_next = result_reg;
    ev = '0;
    unique case (state_reg)
      ST_CONV: begin
        pins_next = '{sck: 1'b1, sdo: 1'b1, busy: 1'b1};
        if (sample_en) begin
          if (conv_cnt_reg == conv_last) begin
            // finish: all pins drop together, word loaded with status bit low
            state_next = ST_SLEEP;
            pins_next = '0;
            conv_cnt_next = 19'h00000;
            sleep_cnt_next = 8'h00;
            out_shift_next = {1'b0, result_in};
            result_next = {1'b0, result_in};
            ev.conv_done = 1'b1;
          end else begin
            conv_cnt_next = 19'(conv_cnt_reg + 19'h00001);
          end
        end
      end
      ST_SLEEP: begin
        // wake once the least sleep has passed, only while clock_source_select is high
        if (clock_source_select && sleep_cnt_reg == SLEEP_LAST) begin
          state_next = ST_OUT;
          half_cnt_next = 8'h00;
          bit_cnt_next = 6'h00;
        end else if (sleep_cnt_reg != SLEEP_LAST) begin
          sleep_cnt_next = 8'(sleep_cnt_reg + 8'h01);
        end
      end
      ST_OUT: begin
        if (half_cnt_reg != HALF_LAST) begin
          half_cnt_next = 8'(half_cnt_reg + 8'h01);
        end else begin
          half_cnt_next = 8'h00;
          if (bit_cnt_reg == WORD_END) begin
            // half a period after the 32nd rise, so the last bit stands through that rise
            state_next = ST_CONV;
            pins_next = '{sck: 1'b1, sdo: 1'b1, busy: 1'b1};
            conv_cnt_next = 19'h00000;
            ev.word_sent = 1'b1;
            config_next = in_shift_reg;
            osr_log2_next = osr_decode(in_shift_reg[12:9]);
          end else if (!pins_reg.sck) begin
            // rising edge: take one configuration bit on each of the first 13 rises, sdo left as it stands
            pins_next.sck = 1'b1;
            bit_cnt_next = 6'(bit_cnt_reg + 6'h01);
            if (bit_cnt_reg <= PROG_LAST) begin
              in_shift_next = {in_shift_reg[11:0], sdi};
            end
          end else begin
            // falling edge: next bit, msb first
            pins_next.sck = 1'b0;
            pins_next.sdo = out_shift_reg[30];
            out_shift_next = {out_shift_reg[30:0], 1'b0};
          end
        end
      end
    endcase
  end

  // register the sequencer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= ST_CONV;
      pins_reg <= '{sck: 1'b1, sdo: 1'b1, busy: 1'b1};
      conv_cnt_reg <= 19'h00000;
      sleep_cnt_reg <= 8'h00;
      half_cnt_reg <= 8'h00;
      bit_cnt_reg <= 6'h00;
      out_shift_reg <= 32'h00000000;
      in_shift_reg <= 13'h0000;
      config_reg <= CONFIG_RST;
      osr_log2_reg <= OSR_LOG2_RST_P;
      result_reg <= 32'h00000000;
    end else begin
      state_reg <= state_next;
      pins_reg <= pins_next;
      conv_cnt_reg <= conv_cnt_next;
      sleep_cnt_reg <= sleep_cnt_next;
      half_cnt_reg <= half_cnt_next;
      bit_cnt_reg <= bit_cnt_next;
      out_shift_reg <= out_shift_next;
      in_shift_reg <= in_shift_next;
      config_reg <= config_next;
      osr_log2_reg <= osr_log2_next;
      result_reg <= result_next;
    end
  end

  assign serial_pins = pins_reg;

  // ---------------- bus slave and interrupts ----------------
  logic [7:0] addr_reg, addr_next; // data phase address
  logic wr_pend_reg, wr_pend_next; // write data phase pending
  logic [31:0] hrdata_reg, hrdata_next; // read data
  logic [1:0] mask_reg, mask_next; // interrupt mask
  logic [1:0] irq_stat_reg, irq_stat_next; // sticky events
  logic irq_reg, irq_next; // interrupt output
  logic acc; // valid word transfer accepted
  logic mapped; // address lies in our page
  logic [31:0] rdata; // read mux

  // decode, read mux, writes and sticky status
  always_comb begin
    acc = hsel && hready && htrans[1] && (hsize == 3'b010);
    mapped = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'b00);
    rdata = 32'h00000000;
    if (mapped) begin
      unique case (haddr[7:0])
        REG_CTRL: rdata = ctrl_reg;
        REG_STATUS: rdata = {22'h000000, use_ext, osr_log2_reg, state_reg, pins_reg};
        REG_CONFIG: rdata = {19'h00000, config_reg};
        REG_RESULT: rdata = result_reg;
        REG_IRQ_STATUS: rdata = {30'h00000000, irq_stat_reg};
        REG_IRQ_MASK: rdata = {30'h00000000, mask_reg};
        default: rdata = 32'h00000000; // unmapped reads zero
      endcase
    end
    addr_next = acc ? (mapped ? haddr[7:0] : 8'hff) : addr_reg;
    wr_pend_next = acc && hwrite;
    hrdata_next = (acc && !hwrite) ? rdata : hrdata_reg;
    ctrl_next = ctrl_reg;
    mask_next = mask_reg;
    if (wr_pend_reg && addr_reg == REG_CTRL) begin
      ctrl_next = {31'h00000000, hwdata[CTRL_FORCE_OSC_BIT]};
    end
    if (wr_pend_reg && addr_reg == REG_IRQ_MASK) begin
      mask_next = hwdata[1:0];
    end
    irq_stat_next = irq_stat_reg;
    if (acc && !hwrite && mapped && haddr[7:0] == REG_IRQ_STATUS) begin
      irq_stat_next = 2'h0; // read clears
    end
    irq_stat_next = irq_stat_next | ev; // a new event beats the clear
    irq_next = |(irq_stat_next & mask_next);
  end

  // register the bus side
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_reg <= 8'h00;
      wr_pend_reg <= 1'b0;
      hrdata_reg <= 32'h00000000;
      ctrl_reg <= 32'h00000000;
      mask_reg <= IRQ_MASK_RST;
      irq_stat_reg <= 2'h0;
      irq_reg <= 1'b0;
    end else begin
      addr_reg <= addr_next;
      wr_pend_reg <= wr_pend_next;
      hrdata_reg <= hrdata_next;
      ctrl_reg <= ctrl_next;
      mask_reg <= mask_next;
      irq_stat_reg <= irq_stat_next;
      irq_reg <= irq_next;
    end
  end

  assign hrdata = hrdata_reg;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign irq = irq_reg;

  // ---------------- checks ----------------
  logic [5:0] rises_reg, rises_next; // sck rises in this word

  // count rises since sleep began
  always_comb begin
    rises_next = rises_reg;
    if (state_reg == ST_SLEEP) begin
      rises_next = 6'h00;
    end else if (state_reg == ST_OUT && pins_next.sck && !pins_reg.sck) begin
      rises_next = 6'(rises_reg + 6'h01);
    end
  end

  // register the check counter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rises_reg <= 6'h00;
    end else begin
      rises_reg <= rises_next;
    end
  end

  a_conv_pins_high: assert property (@(posedge hclk) disable iff (!hresetn)
    state_reg == ST_CONV |-> pins_reg.sck && pins_reg.sdo && pins_reg.busy)
    else $error("pins not high during conversion");
  a_done_pins_low: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(state_reg) == ST_CONV && state_reg == ST_SLEEP |-> pins_reg == '0)
    else $error("pins not low after conversion");
  a_sleep_min_time: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(state_reg) == ST_SLEEP && state_reg == ST_OUT |-> $past(sleep_cnt_reg) == SLEEP_LAST)
    else $error("sleep ended early");
  a_word_bits: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(state_reg) == ST_OUT && state_reg == ST_CONV |-> rises_reg == 6'h20)
    else $error("word not 32 rising edges");
  a_sdo_on_fall: assert property (@(posedge hclk) disable iff (!hresetn)
    state_reg == ST_OUT && $past(state_reg) == ST_OUT && $changed(pins_reg.sdo) |-> $fell(pins_reg.sck))
    else $error("data changed off a falling edge");
  a_after_word: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(state_reg) == ST_OUT && state_reg == ST_CONV |-> $past(pins_reg.sck) ##1 pins_reg.sck && pins_reg.sdo)
    else $error("clock or data not high after word");
  a_status_first: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(state_reg == ST_OUT) |-> !pins_reg.sdo && !pins_reg.sck)
    else $error("status bit not leading");
  a_osr_range: assert property (@(posedge hclk) disable iff (!hresetn)
    osr_log2_reg >= OSR_LOG2_MIN && osr_log2_reg <= OSR_LOG2_MAX)
    else $error("ratio out of range");
  a_sdi_high_max: assert property (@(posedge hclk) disable iff (!hresetn)
    ev.word_sent && in_shift_reg[12:9] == 4'hf |=> osr_log2_reg == OSR_LOG2_MAX)
    else $error("all-ones input not largest ratio");
  a_ext_div_five: assert property (@(posedge hclk) disable iff (!hresetn)
    use_ext && sample_en |-> ext_rise && ext_div_reg == EXT_LAST)
    else $error("external sample not every fifth edge");
endmodule
`default_nettype wire

// >>> testbench/aicr_capture.sv
`timescale 1ns/1ps
`default_nettype none
// far-side controller: gathers each result word on the generated serial clock
module aicr_capture (
  input wire logic hclk, // system clock
  input wire logic hresetn, // async reset, active low
  input wire aicr_pkg::aicr_pins_type pins, // serial pins from the device
  input wire logic [12:0] cfg_word, // configuration shifted out, first bit leads
  output logic sdi, // serial configuration toward the device
  output logic [31:0] last_word, // last complete word
  output logic [15:0] word_count // words received so far
);
  import aicr_pkg::*;
  logic sck_d; // serial clock one cycle late
  logic [5:0] rise_cnt; // rises seen in the current word
  logic [31:0] shift_reg; // word being gathered
  // take sdo on each rise, move sdi on each fall so it is settled before the next rise
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sck_d <= 1'b1;
      rise_cnt <= 6'h00;
      shift_reg <= 32'h00000000;
      last_word <= 32'h00000000;
      word_count <= 16'h0000;
      sdi <= 1'b1;
    end else begin
      sck_d <= pins.sck;
      if (pins.sck && !sck_d) begin
        shift_reg <= {shift_reg[30:0], pins.sdo};
        if (rise_cnt == 6'd31) begin
          last_word <= {shift_reg[30:0], pins.sdo};
          word_count <= word_count + 16'h0001;
          rise_cnt <= 6'h00;
        end else begin
          rise_cnt <= rise_cnt + 6'h01;
        end
      end else if (!pins.sck && sck_d) begin
        sdi <= (rise_cnt < 6'd13) ? cfg_word[4'd12 - rise_cnt[3:0]] : 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// >>> testbench/aicr_readout_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) \
  begin \
    check_count++; \
    if ((got) !== (ex)) begin \
      err_total++; \
      $display("BAD %s expected %h seen %h", nm, ex, got); \
    end \
  end
module aicr_readout_test;
  import aicr_pkg::*;
  localparam int LIMIT = 40000; // cycles before the run is cut short
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic clock_source_select, external_clock_input, sdi, ext_run;
  logic [30:0] result_in; // value the modulator hands over
  logic [12:0] cfg_word; // configuration the far side shifts in
  logic [31:0] last_word;
  logic [15:0] word_count;
  aicr_pins_type serial_pins;
  int cyc, end_cyc, word_cyc, err_total, check_count;
  assign hready = hreadyout; // single slave drives bus ready
  // smallest ratio after reset keeps the first conversion short
  aicr_readout #(.OSC_DIV_P(1), .SCK_HALF_P(2), .OSR_LOG2_RST_P(4'h6)) aicr_readout_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .irq(irq), .clock_source_select(clock_source_select),
    .external_clock_input(external_clock_input), .sdi(sdi), .result_in(result_in),
    .serial_pins(serial_pins));
  aicr_capture aicr_capture_inst (.hclk(hclk), .hresetn(hresetn), .pins(serial_pins),
    .cfg_word(cfg_word), .sdi(sdi), .last_word(last_word), .word_count(word_count));
  // system clock, 8 ns period
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  // external modulator clock, one toggle per system clock while enabled
  always @(posedge hclk) begin
    external_clock_input <= ext_run ? !external_clock_input : 1'b0;
  end
  // cycle count and hang guard
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      err_total++;
      $display("BAD timeout expected %0d seen %0d", LIMIT - 1, cyc);
      results();
    end
  end
  // one single word transfer: address phase, then data phase
  task automatic bus_cycle(input logic [7:0] addr, input logic wr, input logic [31:0] wdata,
    output logic [31:0] rdata);
    hsel <= 1'b1;
    haddr <= {24'h000000, addr};
    hwrite <= wr;
    htrans <= 2'b10;
    hsize <= 3'b010;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wdata;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rdata = hrdata;
  endtask
  // wait for a conversion to end, pins must show converting until then
  task automatic wait_end(input int lim, output int n);
    bit odd;
    odd = 1'b0;
    n = 0;
    while (serial_pins !== 3'b000 && n < lim) begin
      if (serial_pins !== 3'b111) odd = 1'b1;
      @(posedge hclk);
      n++;
    end
    end_cyc = cyc;
    n = cyc - word_cyc;
    `CHK("busy pins", 1'b0, odd)
    `CHK("end pins", 3'b000, serial_pins)
  endtask
  // wait for the device to send a whole word on its own and judge it
  task automatic read_word(input logic [30:0] res, input bit chk_slp);
    logic [15:0] wc;
    int n;
    wc = word_count;
    n = 0;
    while (serial_pins.sck !== 1'b1 && n < 2000) begin
      @(posedge hclk);
      n++;
    end
    if (chk_slp) begin
      `CHK("sleep", 1'b1, (cyc - end_cyc >= SLEEP_CYC) && (cyc - end_cyc <= SLEEP_CYC + 8))
    end
    while (word_count === wc && n < 2000) begin
      @(posedge hclk);
      n++;
    end
    word_cyc = cyc;
    `CHK("word", {1'b0, res}, last_word)
    // the device ends the word half a serial clock after the 32nd rise
    repeat (2) @(posedge hclk);
    `CHK("after word pins", 3'b111, serial_pins)
  endtask
  // unmapped read and interrupt mask access
  task automatic t_regs();
    logic [31:0] rd;
    bus_cycle(8'h20, 1'b0, 32'h0, rd);
    `CHK("unmapped", 32'h00000000, rd)
    `CHK("resp", 2'b01, {hresp, hreadyout})
    bus_cycle(REG_IRQ_MASK, 1'b1, 32'h00000001, rd);
    bus_cycle(REG_IRQ_MASK, 1'b0, 32'h0, rd);
    `CHK("mask", 32'h00000001, rd)
    `CHK("irq idle", 1'b0, irq)
    $display("done regs");
  endtask
  // first conversion, interrupt, first word and configuration commit
  task automatic t_first();
    logic [31:0] rd;
    int n;
    cfg_word <= 13'h0200;
    result_in <= 31'h2ac35a5c;
    wait_end(2000, n);
    repeat (2) @(posedge hclk);
    `CHK("irq on done", 1'b1, irq)
    bus_cycle(REG_IRQ_STATUS, 1'b0, 32'h0, rd);
    `CHK("irq status", 1'b1, rd[0])
    `CHK("irq cleared", 1'b0, irq)
    read_word(31'h2ac35a5c, 1'b1);
    `CHK("irq masked", 1'b0, irq)
    bus_cycle(REG_IRQ_STATUS, 1'b0, 32'h0, rd);
    `CHK("word event", 32'h00000002, rd)
    bus_cycle(REG_CONFIG, 1'b0, 32'h0, rd);
    `CHK("config", 32'h00000200, rd)
    bus_cycle(REG_RESULT, 1'b0, 32'h0, rd);
    `CHK("result reg", {1'b0, 31'h2ac35a5c}, rd)
    $display("done first");
  endtask
  // ratio 64 then 128 on the internal rate: length doubles
  task automatic t_ratio();
    logic [31:0] rd;
    int n;
    cfg_word <= 13'h0400;
    result_in <= 31'h12345678;
    wait_end(2000, n);
    `CHK("len 64", 1'b1, n >= 512 && n <= 528)
    bus_cycle(REG_STATUS, 1'b0, 32'h0, rd);
    `CHK("ratio 64", 4'h6, rd[8:5])
    read_word(31'h12345678, 1'b1);
    cfg_word <= 13'h0200;
    result_in <= 31'h7fffffff;
    wait_end(3000, n);
    `CHK("len 128", 1'b1, n >= 1024 && n <= 1040)
    read_word(31'h7fffffff, 1'b1);
    $display("done ratio");
  endtask
  // serial clock select low keeps the device asleep
  task automatic t_select();
    int n;
    clock_source_select <= 1'b0;
    result_in <= 31'h00000001;
    wait_end(2000, n);
    repeat (200) @(posedge hclk);
    `CHK("held asleep", 3'b000, serial_pins)
    clock_source_select <= 1'b1;
    read_word(31'h00000001, 1'b0);
    $display("done select");
  endtask
  // external modulator clock divided by five
  task automatic t_ext();
    logic [31:0] rd;
    int n;
    ext_run <= 1'b1;
    result_in <= 31'h55aa33cc;
    wait_end(8000, n);
    read_word(31'h55aa33cc, 1'b1);
    wait_end(8000, n);
    // 512 samples ten clocks apart, first one up to one sample after the start
    `CHK("len ext", 1'b1, n >= 5110 && n <= 5130)
    bus_cycle(REG_STATUS, 1'b0, 32'h0, rd);
    `CHK("use ext", 1'b1, rd[9])
    bus_cycle(REG_CTRL, 1'b1, 32'h00000001, rd);
    bus_cycle(REG_STATUS, 1'b0, 32'h0, rd);
    `CHK("forced osc", 1'b0, rd[9])
    bus_cycle(REG_CTRL, 1'b1, 32'h00000000, rd);
    ext_run <= 1'b0;
    read_word(31'h55aa33cc, 1'b1);
    $display("done ext");
  endtask
  // serial input held high selects the largest ratio
  task automatic t_high();
    logic [31:0] rd;
    int n;
    cfg_word <= 13'h1fff;
    result_in <= 31'h0f0f0f0f;
    wait_end(2000, n);
    read_word(31'h0f0f0f0f, 1'b1);
    bus_cycle(REG_STATUS, 1'b0, 32'h0, rd);
    `CHK("ratio top", 4'hf, rd[8:5])
    $display("done high");
  endtask
  // counts and verdict, then stop
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // reset, then the scenarios in order
  initial begin
    end_cyc = 0;
    word_cyc = 0;
    err_total = 0;
    check_count = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    clock_source_select = 1'b1;
    ext_run = 1'b0;
    result_in = 31'h0;
    cfg_word = 13'h0200;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs();
    t_first();
    t_ratio();
    t_select();
    t_ext();
    t_high();
    results();
  end
endmodule
`default_nettype wire
